// [tb/crps_card_model.sv]
/* card model: busy after power-up or a hard reset outside disk mode, state cleared on either.
   assumes the host pull-down holds the ready line low while unpowered. */
`timescale 1ns/1ps
module crps_card_model #(
	parameter int BUSY_CYC = 6
) (
	input wire logic clk_sys_i,
	input wire logic power_i,
	input wire logic reset_i,
	input wire logic disk_i,
	output logic ready_busy_line_o
);
	int busy_q = 0;
	logic [7:0] regs_q = 8'h00;
	always @(posedge clk_sys_i) begin
		if (!power_i || (reset_i && !disk_i)) begin
			busy_q <= BUSY_CYC;
			regs_q <= 8'h00;
		end else if (busy_q > 0) begin
			busy_q <= busy_q - 1;
		end
	end
	assign ready_busy_line_o = power_i && busy_q == 0;
endmodule

// [tb/crps_host_checker.sv]
/* assertions on the card sequencer ports, bound to crps_host.
   assumes clk_en_i is held high. */
`timescale 1ns/1ps
module crps_host_checker #(
	parameter longint unsigned RESET_PULSE_CYC = 4,
	parameter longint unsigned RESET_SETUP_CYC = 8,
	parameter longint unsigned CE_RECOVER_CYC = 2
) (
	// user side
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic disk_mode_i,
	input wire logic access_active_i,
	input wire logic access_ok_o,
	input wire logic [2:0] state_o,
	// card pins
	input wire logic card_detect_first_n_i,
	input wire logic card_detect_second_n_i,
	input wire logic ready_busy_line_i,
	input wire logic card_power_en_o,
	input wire logic card_reset_o,
	input wire logic card_oe_n_o,
	input wire logic card_ce_n_o
);
	// ----
	// run length of the previous state
	// ----
	logic [2:0] st_q;
	logic [31:0] run_q;
	logic leave_w;
	assign leave_w = state_o != st_q;
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q <= 3'h0;
			run_q <= 32'h0;
		end else begin
			st_q <= state_o;
			run_q <= (state_o == st_q) ? run_q + 32'h1 : 32'h1;
		end
	end
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	property p_det; (state_o == 3'h1 && st_q == 3'h0) |->
		!$past(card_detect_first_n_i, 3) && !$past(card_detect_second_n_i, 3); endproperty
	a_det: assert property (p_det) else $error("supply without card");
	property p_oe_mem; (!disk_mode_i && st_q inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h6}) |->
		card_oe_n_o; endproperty
	a_oe_mem: assert property (p_oe_mem) else $error("strobe low in power-up");
	property p_oe_disk; (disk_mode_i && st_q inside {3'h4, 3'h5}) |-> !card_oe_n_o; endproperty
	a_oe_disk: assert property (p_oe_disk) else $error("strobe high in disk mode");
	property p_pulse; (leave_w && st_q == 3'h2) |->
		card_reset_o && run_q == 32'(RESET_PULSE_CYC); endproperty
	a_pulse: assert property (p_pulse) else $error("reset pulse length");
	property p_setup; (leave_w && st_q == 3'h3) |->
		state_o == 3'h4 && run_q == 32'(RESET_SETUP_CYC); endproperty
	a_setup: assert property (p_setup) else $error("reset setup length");
	property p_recover; (leave_w && st_q == 3'h6) |->
		card_ce_n_o && !card_reset_o && run_q == 32'(CE_RECOVER_CYC); endproperty
	a_recover: assert property (p_recover) else $error("enable recovery");
	property p_ready; access_ok_o |-> $past(ready_busy_line_i, 3) && st_q == 3'h5; endproperty
	a_ready: assert property (p_ready) else $error("access while busy");
	property p_loss; card_detect_second_n_i [*5] |-> state_o == 3'h0; endproperty
	a_loss: assert property (p_loss) else $error("not off after removal");
	property p_cut; $fell(card_power_en_o) |-> !$past(access_active_i, 2); endproperty
	a_cut: assert property (p_cut) else $error("supply cut while active");
	property p_disk_hr; (disk_mode_i && st_q == 3'h5) |-> state_o != 3'h2; endproperty
	a_disk_hr: assert property (p_disk_hr) else $error("hard reset in disk mode");
endmodule

bind crps_host crps_host_checker #(.RESET_PULSE_CYC(RESET_PULSE_CYC),
	.RESET_SETUP_CYC(RESET_SETUP_CYC), .CE_RECOVER_CYC(CE_RECOVER_CYC)) i_crps_host_checker (
	.clk_sys_i, .rst_n_i, .disk_mode_i, .access_active_i, .access_ok_o, .state_o,
	.card_detect_first_n_i, .card_detect_second_n_i, .ready_busy_line_i, .card_power_en_o,
	.card_reset_o, .card_oe_n_o, .card_ce_n_o);

// [tb/testbench.sv]
/* bench for crps_host with the card model; expected state steps kept in a queue.
   assumes small sequencer counts. */
`timescale 1ns/1ps
module testbench;
	logic clk_sys_i = 1'b0;
	logic rst_n_i, clk_en, disk, pwr_req, hr_req, acc_act, ready, access_ok, seq_busy;
	logic powered, power_en, card_rst, oe_n, ce_n, cutoff;
	logic [1:0] det_n;
	logic [2:0] state;
	logic [2:0] last_st = 3'h0;
	int err_count = 0;
	int checks = 0;
	int exp_q[$];
	always #4 clk_sys_i = ~clk_sys_i;
	crps_host #(.RESET_PULSE_CYC(4), .RESET_SETUP_CYC(8), .CE_RECOVER_CYC(2),
		.POWER_SETUP_CYC(8)) i_crps_host (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.clk_en_i(clk_en), .disk_mode_i(disk), .power_req_i(pwr_req),
		.hard_reset_req_i(hr_req), .access_active_i(acc_act), .access_ok_o(access_ok),
		.seq_busy_o(seq_busy), .powered_o(powered), .cutoff_ok_o(cutoff), .state_o(state),
		.card_detect_first_n_i(det_n[0]), .card_detect_second_n_i(det_n[1]),
		.ready_busy_line_i(ready), .card_power_en_o(power_en), .card_reset_o(card_rst),
		.card_oe_n_o(oe_n), .card_ce_n_o(ce_n));
	crps_card_model i_crps_card_model (.clk_sys_i(clk_sys_i), .power_i(power_en),
		.reset_i(card_rst), .disk_i(disk), .ready_busy_line_o(ready));
	task automatic cmp(input logic [2:0] got, input logic [2:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	task automatic drain;
		int n;
		n = 0;
		while (exp_q.size() != 0 && n < 300) begin
			step(1);
			n++;
		end
		cmp(3'(exp_q.size()), 3'h0, "missing state");
		step(3);
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	always @(negedge clk_sys_i) begin
		if (rst_n_i && state !== last_st) begin
			last_st = state;
			if (exp_q.size() != 0) cmp(state, 3'(exp_q.pop_front()), "state step");
			else cmp(state, 3'h7, "unexpected state");
		end
	end
	initial begin
		#80000;
		cmp(3'h1, 3'h0, "watchdog");
		final_report();
	end
	initial begin
		rst_n_i = 1'b0;
		{disk, pwr_req, hr_req, acc_act, clk_en} = 5'b00001;
		det_n = 2'b11;
		void'($urandom(32'h1a6c5c6f));
		step(8);
		rst_n_i = 1'b1;
		for (int m = 0; m < 2; m++) begin
			disk = m[0];
			pwr_req = 1'b1;
			step($urandom_range(4, 12));
			cmp(state, 3'h0, "powered without card");
			exp_q = '{1, 4, 5};
			det_n = 2'b00;
			drain();
			cmp({access_ok, powered, seq_busy}, 3'h6, "ready status");
			cmp(cutoff, 1'b1, "cutoff allowed");
			cmp({oe_n, ce_n}, 3'h0, "enables");
			if (!m[0]) exp_q = '{2, 6, 3, 4, 5};
			hr_req = 1'b1;
			step(1);
			hr_req = 1'b0;
			step($urandom_range(1, 6));
			drain();
			cmp(state, 3'h5, "after hard reset");
			acc_act = ~m[0];
			pwr_req = m[0];
			step(10);
			cmp(state, 3'h5, "held while active");
			clk_en = 1'b0;
			acc_act = 1'b0;
			step(4);
			cmp(state, 3'h5, "frozen by enable");
			clk_en = 1'b1;
			exp_q = '{0};
			acc_act = 1'b0;
			det_n = {m[0], 1'b0};
			drain();
			cmp(power_en, 1'b0, "supply off");
			det_n = 2'b11;
			pwr_req = 1'b0;
			step(4);
			$display("test %0d done", m);
		end
		final_report();
	end
endmodule

// [verilog/crps_host.sv]
/*
 * host-side sequencer for a removable flash card: gates card supply on insertion, runs the
 * power-on and hard reset sequences, drives the output-enable strobe for the selected mode,
 * and grants card access only once the card reports ready.
 * assumes card pins are asynchronous (synchronised here) and user requests are on clk_sys_i.
 * clk_en_i low freezes every register except the reset release pair.
 * hard reset requests count only in READY and never in disk-interface mode.
 */
`timescale 1ns/1ps
// Notes on behaviour
// R1: card clears registers on reset or power loss
// R2: no access until ready/busy line high
// R3: hard reset pulse at least 10 us
// R4: wait 100 ms after hard reset
// R5: wait 1 us card-enable recovery
// R6: hard reset only in memory/io modes
// R7: reset inactive and ready allows power cutoff
// R8: supply power only when both detects present
// R9: output enable high during power-on reset
// R10: disk-interface mode ties output enable low
// R11: no insertion/removal while disk mode active
// R12: no power removal during internal operations
// R13: any detect loss restarts full power sequence
module crps_host #(
	parameter longint unsigned RESET_PULSE_CYC = crps_pkg::RESET_PULSE_CYC,
	parameter longint unsigned RESET_SETUP_CYC = crps_pkg::RESET_SETUP_CYC,
	parameter longint unsigned CE_RECOVER_CYC = crps_pkg::CE_RECOVER_CYC,
	parameter longint unsigned POWER_SETUP_CYC = crps_pkg::POWER_SETUP_CYC
) (
	// clock, reset, enable
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic clk_en_i,
	// user requests
	input wire logic disk_mode_i,
	input wire logic power_req_i,
	input wire logic hard_reset_req_i,
	input wire logic access_active_i,
	// user status
	output logic access_ok_o,
	output logic seq_busy_o,
	output logic powered_o,
	output logic cutoff_ok_o,
	output logic [2:0] state_o,
	// card pins
	input wire logic card_detect_first_n_i,
	input wire logic card_detect_second_n_i,
	input wire logic ready_busy_line_i,
	output logic card_power_en_o,
	output logic card_reset_o,
	output logic card_oe_n_o,
	output logic card_ce_n_o
);

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	// the release pair ignores the enable so reset always completes
	logic rst_meta_q;
	logic rst_sync_q;
	logic rst_n;

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end
	assign rst_n = rst_sync_q;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0] pins_sync;

	crps_sync #(
		.WIDTH(3),
		.RST_VAL(3'h3)
	) u_sync (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n),
		.clk_en_i(clk_en_i),
		.async_i({ready_busy_line_i, card_detect_second_n_i, card_detect_first_n_i}),
		.sync_o(pins_sync)
	);

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	wire det_first = ~pins_sync[0];
	wire det_second = ~pins_sync[1];
	wire card_in = det_first & det_second; // see R8
	wire card_ready = pins_sync[2];
	logic mode_disk_q;

	function automatic logic [crps_pkg::CNT_W-1:0] cnt_load(input longint unsigned cyc);
		begin
			cnt_load = (cyc > 1) ? crps_pkg::CNT_W'(cyc - 1) : crps_pkg::CNT_ZERO;
		end
	endfunction

	// every wait state lasts exactly its own count
	wire [crps_pkg::CNT_W-1:0] load_power = cnt_load(POWER_SETUP_CYC);
	wire [crps_pkg::CNT_W-1:0] load_pulse = cnt_load(RESET_PULSE_CYC);
	wire [crps_pkg::CNT_W-1:0] load_recover = cnt_load(CE_RECOVER_CYC);
	wire [crps_pkg::CNT_W-1:0] load_setup = cnt_load(RESET_SETUP_CYC);

	// ----------------------------------------------------------------
	// transition requests
	// ----------------------------------------------------------------
	// power-up is only taken with both detects seen present
	wire go_power = power_req_i & card_in; // see R8
	// power-off waits for the request to drop and any access to finish
	wire go_off = ~power_req_i & ~access_active_i; // see R7 see R12
	// hard reset belongs to the memory and io card modes only
	wire go_hard_reset = hard_reset_req_i & ~mode_disk_q; // see R6

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	crps_pkg::crps_state_e state_q;
	crps_pkg::crps_state_e state_d;
	logic [crps_pkg::CNT_W-1:0] cnt_q;
	logic [crps_pkg::CNT_W-1:0] cnt_d;
	wire cnt_done = (cnt_q == crps_pkg::CNT_ZERO);
	// the counter parks at zero until the next load
	wire [crps_pkg::CNT_W-1:0] cnt_dec = cnt_done ? cnt_q : cnt_q - 1'b1;
	// a detect loss always wins; hot-removal in disk mode is the user's duty
	wire card_lost = ~card_in; // see R13 see R11

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_dec;
		if (card_lost) begin
			state_d = crps_pkg::CRPS_OFF; // see R13
			cnt_d = crps_pkg::CNT_ZERO;
		end else begin
			case (state_q)
				crps_pkg::CRPS_OFF: begin
					if (go_power) begin
						state_d = crps_pkg::CRPS_PWR_UP; // see R8
						cnt_d = load_power;
					end
				end
				crps_pkg::CRPS_PWR_UP: begin
					if (cnt_done) begin
						state_d = crps_pkg::CRPS_WAIT_RDY;
					end
				end
				crps_pkg::CRPS_RST_PULSE: begin
					if (cnt_done) begin
						state_d = crps_pkg::CRPS_CE_RECOVER; // see R5
						cnt_d = load_recover;
					end
				end
				crps_pkg::CRPS_CE_RECOVER: begin
					if (cnt_done) begin
						state_d = crps_pkg::CRPS_RST_SETUP; // see R4
						cnt_d = load_setup;
					end
				end
				crps_pkg::CRPS_RST_SETUP: begin
					if (cnt_done) begin
						state_d = crps_pkg::CRPS_WAIT_RDY;
					end
				end
				crps_pkg::CRPS_WAIT_RDY: begin
					if (card_ready) begin
						state_d = crps_pkg::CRPS_READY; // see R2
					end
				end
				crps_pkg::CRPS_READY: begin
					if (!card_ready) begin
						state_d = crps_pkg::CRPS_WAIT_RDY; // see R2
					end else if (go_off) begin
						state_d = crps_pkg::CRPS_OFF; // see R7 see R12
					end else if (go_hard_reset) begin
						state_d = crps_pkg::CRPS_RST_PULSE; // see R6 see R3
						cnt_d = load_pulse;
					end
				end
				default: begin
					state_d = crps_pkg::CRPS_OFF;
					cnt_d = crps_pkg::CNT_ZERO;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= crps_pkg::CRPS_OFF;
		end else if (clk_en_i) begin
			state_q <= state_d;
		end
	end

	// the wait counter moves only with the clock enable
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= crps_pkg::CNT_ZERO;
		end else if (clk_en_i) begin
			cnt_q <= cnt_d;
		end
	end

	// ----------------------------------------------------------------
	// mode latch
	// ----------------------------------------------------------------
	// mode is latched only while the card is unpowered
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			mode_disk_q <= 1'b0;
		end else if (clk_en_i && state_q == crps_pkg::CRPS_OFF) begin
			mode_disk_q <= disk_mode_i;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	wire in_off = (state_q == crps_pkg::CRPS_OFF);
	wire in_ready = (state_q == crps_pkg::CRPS_READY);
	wire in_pulse = (state_q == crps_pkg::CRPS_RST_PULSE);
	wire in_pwrup = (state_q == crps_pkg::CRPS_PWR_UP);
	wire in_ce_hold = in_pulse || (state_q == crps_pkg::CRPS_CE_RECOVER);
	// card loses all register contents once power drops
	wire power_d = ~in_off & card_in; // see R8 see R1
	wire oe_n_d = mode_disk_q ? 1'b0 : (in_pwrup | ~in_ready); // see R9 see R10
	wire reset_d = in_pulse; // see R3
	wire ce_n_d = in_ce_hold | ~in_ready; // see R5
	wire access_d = in_ready & card_ready; // see R2

	logic power_q;
	logic reset_q;
	logic oe_n_q;
	logic ce_n_q;
	logic access_q;

	// ----------------------------------------------------------------
	// card pin registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			power_q <= 1'b0;
		end else if (clk_en_i) begin
			power_q <= power_d;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			reset_q <= 1'b0;
		end else if (clk_en_i) begin
			reset_q <= reset_d;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			oe_n_q <= 1'b1;
		end else if (clk_en_i) begin
			oe_n_q <= oe_n_d;
		end
	end

	// card enable stays high through the pulse and the recovery wait
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			ce_n_q <= 1'b1;
		end else if (clk_en_i) begin
			ce_n_q <= ce_n_d;
		end
	end

	// ----------------------------------------------------------------
	// user status
	// ----------------------------------------------------------------
	// access is granted two cycles after the card is first seen ready in CRPS_WAIT_RDY
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			access_q <= 1'b0;
		end else if (clk_en_i) begin
			access_q <= access_d;
		end
	end

	// ----------------------------------------------------------------
	// port drive
	// ----------------------------------------------------------------
	assign card_power_en_o = power_q;
	assign card_reset_o = reset_q;
	assign card_oe_n_o = oe_n_q;
	assign card_ce_n_o = ce_n_q;
	assign access_ok_o = access_q;
	assign powered_o = power_q;
	assign seq_busy_o = ~in_off & ~in_ready;
	assign cutoff_ok_o = in_ready & ~reset_q & card_ready; // see R7
	assign state_o = state_q;

endmodule

// [verilog/crps_pkg.sv]
/*
 * constants for the card reset and power sequencer (host side): timing figures in their own
 * units, cycle counts derived at 125 MHz, and the sequencer state encoding.
 * assumes a single 125 MHz system clock; no registers are reached by software.
 */
package crps_pkg;

	// ----------------------------------------------------------------
	// clock
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_PS = 8000;

	// ----------------------------------------------------------------
	// timing figures and cycle counts
	// ----------------------------------------------------------------
	localparam int unsigned RESET_PULSE_WIDTH_US = 10;
	localparam int unsigned RESET_SETUP_MS = 100;
	localparam int unsigned CE_RECOVER_US = 1;
	localparam int unsigned POWER_SETUP_MS = 100;
	// least times round up
	localparam longint unsigned RESET_PULSE_CYC =
		(64'(RESET_PULSE_WIDTH_US) * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam longint unsigned RESET_SETUP_CYC =
		(64'(RESET_SETUP_MS) * 1000000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam longint unsigned CE_RECOVER_CYC =
		(64'(CE_RECOVER_US) * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam longint unsigned POWER_SETUP_CYC =
		(64'(POWER_SETUP_MS) * 1000000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	localparam int unsigned CNT_W = 24;
	localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;

	// ----------------------------------------------------------------
	// sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		CRPS_OFF = 3'b000,
		CRPS_PWR_UP = 3'b001,
		CRPS_RST_PULSE = 3'b010,
		CRPS_RST_SETUP = 3'b011,
		CRPS_WAIT_RDY = 3'b100,
		CRPS_READY = 3'b101,
		CRPS_CE_RECOVER = 3'b110
	} crps_state_e;

endpackage

// [verilog/crps_sync.sv]
/*
 * two flip-flop synchroniser for a bus of pin inputs.
 * assumes the inputs are asynchronous to clk_sys_i; reset value is a parameter.
 */
`timescale 1ns/1ps
module crps_sync #(
	parameter int unsigned WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic clk_en_i,
	// data
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
		end else if (clk_en_i) begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;

endmodule
